//--- rtl/instr_decode.v
// Decode and execute stage for OR-with-file, move file, load literal, store W and no-op.
// Assumes instr is valid in every cycle from the fetch logic on this clock, with the file
// address supplied one cycle early on next_faddr so the file read is ready at execute.
`timescale 1ns/1ps
`include "instr_decode_defs.vh"

// Functional notes
// - Opcode 000100 d fffffff ORs the working register with file register f into the chosen destination.
// - A clear destination bit sends the result of a file instruction to the working register.
// - A set destination bit sends the result back to the addressed file register.
// - Move file and OR-with-file set the zero flag from their result, so a move to itself tests for zero.
// - Opcode 001000 d fffffff moves file register f to the chosen destination in one cycle.
// - Opcode 1100xx kkkkkkkk loads the literal into the working register, flags untouched, one cycle.
// - Opcode 0000000xx00000 is a no-op that changes neither W, the zero flag nor any file register; the PC still steps.
module instr_decode
(
  input  wire                  clk,
  input  wire                  nrst,
  input  wire [`INSTR_W-1:0]   instr,
  input  wire [`FADDR_W-1:0]   next_faddr,
  output reg  [`DATA_W-1:0]    w_r,
  output reg                   zero_r,
  output reg  [`PC_W-1:0]      pc_r,
  output reg                   illegal_r,
  output reg  [`DATA_W-1:0]    file_wdata_r,
  output reg  [`FADDR_W-1:0]   file_waddr_r,
  output reg                   file_we_r
);

  // One-hot instruction kinds
  localparam [5:0] K_OR    = 6'h01;
  localparam [5:0] K_MOVE  = 6'h02;
  localparam [5:0] K_LIT   = 6'h04;
  localparam [5:0] K_STORE = 6'h08;
  localparam [5:0] K_NOP   = 6'h10;
  localparam [5:0] K_OTHER = 6'h20;

  wire [`DATA_W-1:0]  file_q;
  wire                dest_file;
  wire [`FADDR_W-1:0] faddr;
  wire [`DATA_W-1:0]  lit_byte;
  reg  [5:0]          kind;
  reg  [`DATA_W-1:0]  result;
  reg  [`DATA_W-1:0]  w_nxt;
  reg                 zero_nxt;
  reg                 fwe_nxt;
  reg  [`PC_W-1:0]    pc_nxt;
  reg                 illegal_nxt;

  assign dest_file = instr[`DEST_BIT];
  assign faddr     = instr[`FADDR_W-1:0];
  assign lit_byte  = instr[`DATA_W-1:0];

  // Six-bit major opcode compare, shared by the two file-operand arithmetic kinds
  function op6_is;
    input [`INSTR_W-1:0] i;
    input [5:0]          op;
    begin
      op6_is = (i[`OP6_HI:`OP6_LO] == op);
    end
  endfunction

  // Masked compare for the fixed-field encodings (store and no-op)
  function field_match;
    input [`INSTR_W-1:0] i;
    input [`INSTR_W-1:0] mask;
    input [`INSTR_W-1:0] match;
    begin
      field_match = ((i & mask) == match);
    end
  endfunction

  // Zero test of an ALU result; both flag-setting kinds share it
  function is_zero;
    input [`DATA_W-1:0] v;
    begin
      is_zero = (v == `ZERO_BYTE);
    end
  endfunction

  // Patterns do not overlap, so the order of tests only matters for inputs holding X
  function [5:0] classify;
    input [`INSTR_W-1:0] i;
    begin
      if (op6_is(i, `OP6_OR_W_FILE))
        classify = K_OR;
      else if (op6_is(i, `OP6_MOVE_FILE))
        classify = K_MOVE;
      else if (i[`OP4_HI:`OP4_LO] == `OP4_LOAD_LIT)
        classify = K_LIT;
      else if (field_match(i, `STORE_MASK, `STORE_MATCH))
        classify = K_STORE;
      else if (field_match(i, `NOP_MASK, `NOP_MATCH))
        classify = K_NOP;
      else
        classify = K_OTHER;
    end
  endfunction

  // Write and read share one edge; the memory forwards a same-address write so
  // a store followed at once by a read of that register sees the new byte
  file_regs file_regs_i
  (
    .clk     (clk),
    .wr_en   (fwe_nxt),
    .wr_addr (faddr),
    .wr_data (result),
    .rd_addr (next_faddr),
    .rd_data (file_q)
  );

  always @*
  begin
    // Defaults hold W, the zero flag and the file, so encodings outside the five change none of them
    kind     = classify(instr);
    result   = file_q;
    w_nxt    = w_r;
    zero_nxt = zero_r;
    fwe_nxt  = 1'b0;
    case (kind)
      K_OR:
      begin
        result   = w_r | file_q;
        zero_nxt = is_zero(result);
        if (dest_file)
          fwe_nxt = 1'b1;
        else
          w_nxt = result;
      end
      K_MOVE:
      begin
        result   = file_q;
        zero_nxt = is_zero(result);
        if (dest_file)
          fwe_nxt = 1'b1;
        else
          w_nxt = result;
      end
      // Bits 9:8 are don't-care and take no part in the load
      K_LIT:
        w_nxt = lit_byte;
      K_STORE:
      begin
        // Zero flag keeps its default: a store touches no flag
        result  = w_r;
        fwe_nxt = 1'b1;
      end
      K_NOP:
        w_nxt = w_r;
      default:
        w_nxt = w_r;
    endcase
  end

  // Unrecognised encodings belong to other execute units, so this block only
  // flags them and lets the counter move on
  always @*
  begin
    pc_nxt      = pc_r + `PC_STEP;
    illegal_nxt = (kind == K_OTHER);
  end

  // W changes only through the kinds that write it
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      w_r <= `W_RESET;
    else
      w_r <= w_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      zero_r <= `ZERO_RESET;
    else
      zero_r <= zero_nxt;
  end

  // Wraps at the top of the 13-bit space; paging is left to the branch logic
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pc_r <= `PC_RESET;
    else
      pc_r <= pc_nxt;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      illegal_r <= `ILLEGAL_RESET;
    else
      illegal_r <= illegal_nxt;
  end

  // Observation copy of the file write, registered on the same edge as the memory itself
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      file_wdata_r <= `FWDATA_RESET;
    else
      file_wdata_r <= result;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      file_waddr_r <= `FWADDR_RESET;
    else
      file_waddr_r <= faddr;
  end

  // Strobe stands for exactly one cycle per write
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      file_we_r <= `FWE_RESET;
    else
      file_we_r <= fwe_nxt;
  end

endmodule

//--- rtl/instr_decode_defs.vh
// Opcode fields, widths and reset values for the five-instruction decoder.
// Included by the decoder and its file-register memory; definitions only.
`ifndef INSTR_DECODE_DEFS_VH
`define INSTR_DECODE_DEFS_VH

`define INSTR_W          14
`define DATA_W           8
`define FADDR_W          7
`define PC_W             13
`define FILE_DEPTH       128
`define OP6_HI           13
`define OP6_LO           8
`define OP6_OR_W_FILE    6'h04
`define OP6_MOVE_FILE    6'h08
`define OP4_LOAD_LIT     4'hC
`define OP4_HI           13
`define OP4_LO           10
`define DEST_BIT         7
`define STORE_MASK       14'h3F80
`define STORE_MATCH      14'h0080
`define NOP_MASK         14'h3F9F
`define NOP_MATCH        14'h0000
`define W_RESET          8'h00
`define PC_RESET         13'h0000
`define PC_STEP          13'h0001
`define ZERO_RESET       1'b0
`define ILLEGAL_RESET    1'b0
`define FWDATA_RESET     8'h00
`define FWADDR_RESET     7'h00
`define FWE_RESET        1'b0
`define ZERO_BYTE        8'h00

`endif

//--- rtl/file_regs.v
// Data file register memory, 128 bytes, one write port and one read port.
// Assumes the decoder presents a read address one cycle ahead of use.
`timescale 1ns/1ps
`include "instr_decode_defs.vh"

module file_regs
(
  input  wire                  clk,
  input  wire                  wr_en,
  input  wire [`FADDR_W-1:0]   wr_addr,
  input  wire [`DATA_W-1:0]    wr_data,
  input  wire [`FADDR_W-1:0]   rd_addr,
  output reg  [`DATA_W-1:0]    rd_data
);

  reg [`DATA_W-1:0] mem [0:`FILE_DEPTH-1];

  // Registered read; a same-address write returns the new byte
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (wr_en && (wr_addr == rd_addr))
      rd_data <= wr_data;
    else
      rd_data <= mem[rd_addr];
  end

endmodule

//--- testbench/instr_decode_props.sv
// Checker for the decoder, bound to instr_decode.
// Sees ports only; file contents are judged through the write port.
`timescale 1ns/1ps
module instr_decode_props
(
  input logic        clk,
  input logic        nrst,
  input logic [13:0] instr,
  input logic [6:0]  next_faddr,
  input logic [7:0]  w_r,
  input logic        zero_r,
  input logic [12:0] pc_r,
  input logic        illegal_r,
  input logic [7:0]  file_wdata_r,
  input logic [6:0]  file_waddr_r,
  input logic        file_we_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire f_or = instr[13:8] == 6'h04;
  wire f_mv = instr[13:8] == 6'h08;
  wire lit  = instr[13:10] == 4'hC;
  wire st   = (instr & 14'h3F80) == 14'h0080;
  wire nop  = (instr & 14'h3F9F) == 14'h0000;
  wire d    = instr[7];
  wire [6:0] fa = instr[6:0];
  wire [7:0] k  = instr[7:0];
  wire known = f_or || f_mv || lit || st || nop;
  a_pc_step: assert property (1'b1 |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("pc did not step");
  a_or_to_w: assert property (f_or && !d |=>
    (w_r & $past(w_r)) == $past(w_r) && zero_r == (w_r == 8'h00) && !file_we_r)
    else $error("or into w wrong");
  a_or_to_file: assert property (f_or && d |=> (file_wdata_r & $past(w_r)) == $past(w_r))
    else $error("or into file wrong");
  a_file_dest: assert property ((f_or || f_mv) && d |=>
    file_we_r && file_waddr_r == $past(fa) && $stable(w_r) && zero_r == (file_wdata_r == 8'h00))
    else $error("file destination wrong");
  a_move_w: assert property (f_mv && !d |=> zero_r == (w_r == 8'h00) && !file_we_r)
    else $error("move into w wrong");
  a_load_lit: assert property (lit |=> w_r == $past(k) && $stable(zero_r) && !file_we_r)
    else $error("literal load wrong");
  a_store_w: assert property (st |=>
    file_we_r && file_wdata_r == $past(w_r) && file_waddr_r == $past(fa) && $stable(zero_r))
    else $error("store wrong");
  a_nop_quiet: assert property (nop |=> $stable(w_r) && $stable(zero_r) && !file_we_r && !illegal_r)
    else $error("no-op changed state");
  a_illegal_flag: assert property (1'b1 |=> illegal_r == !$past(known))
    else $error("illegal flag wrong");
endmodule
bind instr_decode instr_decode_props instr_decode_props_i
(
  .clk          (clk),
  .nrst         (nrst),
  .instr        (instr),
  .next_faddr   (next_faddr),
  .w_r          (w_r),
  .zero_r       (zero_r),
  .pc_r         (pc_r),
  .illegal_r    (illegal_r),
  .file_wdata_r (file_wdata_r),
  .file_waddr_r (file_waddr_r),
  .file_we_r    (file_we_r)
);

//--- testbench/instr_decode_bench.sv
// Self-checking bench for the decoder.
// Inputs change at the falling edge; results are read 1 ns after the rising edge.
`timescale 1ns/1ps
module instr_decode_bench;
  logic        clk = 0;
  logic        nrst = 0;
  logic [13:0] instr = 14'h0000;
  logic [6:0]  next_faddr = 7'h00;
  wire  [7:0]  w_r;
  wire         zero_r;
  wire  [12:0] pc_r;
  wire         illegal_r;
  wire  [7:0]  file_wdata_r;
  wire  [6:0]  file_waddr_r;
  wire         file_we_r;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
  instr_decode instr_decode_i
  (
    .clk          (clk),
    .nrst         (nrst),
    .instr        (instr),
    .next_faddr   (next_faddr),
    .w_r          (w_r),
    .zero_r       (zero_r),
    .pc_r         (pc_r),
    .illegal_r    (illegal_r),
    .file_wdata_r (file_wdata_r),
    .file_waddr_r (file_waddr_r),
    .file_we_r    (file_we_r)
  );
  always #2.5 clk = ~clk;
  task automatic test_done;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 400)
    begin
      bad_count++;
      test_done();
    end
  end
  // File address is read at the edge that executes op, so each step passes the operand address of the step after it
  task automatic step(input logic [13:0] op, input logic [6:0] fa);
    logic [12:0] p;
    @(negedge clk);
    p = pc_r;
    instr = op;
    next_faddr = fa;
    @(posedge clk);
    #1;
    `CHK(pc_r, p + 13'h0001)
  endtask
  task automatic t_store;
    step(14'h335A, 7'h7F);
    `CHK(w_r, 8'h5A)
    step(14'h00FF, 7'h7F);
    `CHK({file_we_r, file_waddr_r, file_wdata_r}, {1'b1, 7'h7F, 8'h5A})
  endtask
  task automatic t_or;
    step(14'h300F, 7'h10);
    step(14'h0090, 7'h10);
    step(14'h30A0, 7'h10);
    step(14'h0410, 7'h10);
    `CHK({w_r, zero_r, file_we_r}, {8'hAF, 1'b0, 1'b0})
    step(14'h3040, 7'h10);
    step(14'h0490, 7'h10);
    `CHK({w_r, file_we_r, file_wdata_r}, {8'h40, 1'b1, 8'h4F})
  endtask
  task automatic t_zero;
    step(14'h3000, 7'h20);
    step(14'h00A0, 7'h20);
    step(14'h3033, 7'h20);
    step(14'h08A0, 7'h7F);
    `CHK({w_r, zero_r, file_wdata_r}, {8'h33, 1'b1, 8'h00})
    step(14'h087F, 7'h20);
    `CHK({w_r, zero_r}, {8'h5A, 1'b0})
    step(14'h3000, 7'h20);
    `CHK(zero_r, 1'b0)
    step(14'h0420, 7'h20);
    `CHK({w_r, zero_r}, {8'h00, 1'b1})
  endtask
  task automatic t_nop;
    step(14'h0060, 7'h00);
    step(14'h0000, 7'h00);
    `CHK({w_r, zero_r, file_we_r, illegal_r}, {8'h00, 1'b1, 1'b0, 1'b0})
    step(14'h3835, 7'h00);
    `CHK({w_r, zero_r, file_we_r, illegal_r}, {8'h00, 1'b1, 1'b0, 1'b1})
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    `CHK({pc_r, w_r, zero_r}, 22'h0)
    nrst = 1;
    t_store();
    t_or();
    t_zero();
    t_nop();
    test_done();
  end
endmodule
